/* File: rtl/conv_pkg.sv */
// Overview of operation
// - Selections reach converter only while enabled.
// - Result right-justified, or left with left_adjust.
// - Low byte read locks updates until high read.
// - Done flag sets even when result discarded.
// - Start bit starts, stays set, clears at end.
// - Channel change waits for converter idle; free-running keeps old channel.
// - Trigger rising edge resets prescaler and starts.
// - Trigger level or edges during conversion ignored.
// - Own done flag as trigger runs free.
// - Start bit reads one during any conversion.
// - Prescaler held reset while enable low.
// - Software start waits next conversion clock edge.
// - Normal 15 cycles, first 26 cycles.
// - Sample 4 cycles in, first at 15.
// - Completion writes result unless locked, sets flag, clears start unless free-running.
// - Triggered: sample 4.5, total 15.5 cycles.
// - Free-running restarts at once, start stays set.
// - Gain active: settings change forces long conversion.
// - Selection buffer follows idle, locks during conversion.
// - Sleep with converter idle and auto-trigger off starts a conversion.
package conv_pkg;
   localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
   localparam logic [3:0] ADDR_CHAN     = 4'h2;
   localparam logic [3:0] ADDR_REF_GAIN = 4'h3;
   localparam logic [3:0] ADDR_RES_LOW  = 4'h4;
   localparam logic [3:0] ADDR_RES_HIGH = 4'h5;
   localparam logic [3:0] ADDR_POWER    = 4'h6;
   // Control A fields.
   localparam int BIT_ENABLE = 7;
   localparam int BIT_START  = 6;
   localparam int BIT_AUTO   = 5;
   localparam int BIT_FLAG   = 4;
   localparam int BIT_PRESCALE_LSB = 0;
   // Control B fields.
   localparam int BIT_LEFT_ADJ = 3;
   localparam int BIT_TRIG_LSB = 0;
   // Power register field.
   localparam int BIT_POWER_OFF = 0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] TRIG_SELF  = 3'h0;
   localparam int RESULT_W = 10;
   // Cycle counts are in conversion-clock half cycles so that 4.5 and 15.5 fit.
   localparam logic [5:0] HALF_NORMAL   = 6'h1e;
   localparam logic [5:0] HALF_FIRST    = 6'h34;
   localparam logic [5:0] HALF_AUTO     = 6'h1f;
   localparam logic [5:0] HALF_SH_NORM  = 6'h08;
   localparam logic [5:0] HALF_SH_FIRST = 6'h1e;
   localparam logic [5:0] HALF_SH_AUTO  = 6'h09;
   localparam logic [1:0] SYNC_CPU_CYCLES = 2'h2;
endpackage : conv_pkg

/* File: rtl/sar_adc_sequencer.sv */
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module sar_adc_sequencer (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // Register port.
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output      logic [7:0]  rdata,
   // Trigger sources, sleep state and gain flag.
   input  wire logic [7:0]  trig_sources,
   input  wire logic        cpu_sleep_quiet,
   input  wire logic        gain_active,
   // Analog core.
   input  wire logic [9:0]  sar_result,
   output      logic        analog_enable,
   output      logic [5:0]  analog_channel,
   output      logic [2:0]  analog_reference,
   output      logic        analog_sample,
   output      logic        analog_busy
);
   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] chan_q;
   logic [7:0] refg_q;
   logic       power_off_q;
   logic [7:0] res_low_q;
   logic [7:0] res_high_q;
   logic       lock_q;
   logic       busy_q;
   logic       first_q;
   logic [5:0] half_q;
   logic [5:0] len_q;
   logic [5:0] sh_q;
   logic [7:0] presc_q;
   logic       cclk_q;
   logic       pend_q;
   logic       trig_q;
   logic [1:0] sync_q;
   logic       sleep_q;
   logic [8:0] sel_last_q;
   logic       conv_enable;
   logic       wr_a;
   logic       rd_low;
   logic       rd_high;
   logic [7:0] div_mask;
   logic       half_tick;
   logic       trig_now;
   logic       trig_edge;
   logic       finish;
   logic       restart;
   logic       sw_go;
   logic       sel_change;
   logic [9:0] res_raw;
   logic [15:0] res_word;
   logic [7:0] rd_mux;

   assign conv_enable = ctrl_a_q[conv_pkg::BIT_ENABLE] & ~power_off_q;
   assign wr_a        = wr && addr == conv_pkg::ADDR_CTRL_A;
   assign rd_low      = rd && addr == conv_pkg::ADDR_RES_LOW;
   assign rd_high     = rd && addr == conv_pkg::ADDR_RES_HIGH;
   // Divider by 2 to 256 for the conversion clock; one bit per half period.
   assign div_mask  = (8'h01 << ctrl_a_q[2:0]) - 8'h01;
   assign half_tick = conv_enable && ((presc_q & div_mask) == div_mask);
   assign trig_now  = trig_sources[ctrl_b_q[2:0]];
   assign trig_edge = ctrl_a_q[conv_pkg::BIT_AUTO] && trig_now && !trig_q
                      && ctrl_b_q[2:0] != conv_pkg::TRIG_SELF && !busy_q;
   assign finish    = busy_q && half_tick && half_q == len_q - 6'h01;
   assign restart   = finish && ctrl_a_q[conv_pkg::BIT_AUTO]
                      && ctrl_b_q[2:0] == conv_pkg::TRIG_SELF;
   assign sw_go     = pend_q && half_tick && cclk_q && !busy_q;
   assign sel_change = gain_active && {chan_q[5:0], refg_q[2:0]} != sel_last_q;
   assign res_raw   = sar_result;
   assign res_word  = ctrl_b_q[conv_pkg::BIT_LEFT_ADJ] ? {res_raw, 6'h00}
                                                        : {6'h00, res_raw};
   assign rd_mux = addr == conv_pkg::ADDR_CTRL_A   ? {ctrl_a_q[7], busy_q | pend_q | sync_q != 2'h0,
                                                      ctrl_a_q[5:0]} :
                   addr == conv_pkg::ADDR_CTRL_B   ? ctrl_b_q :
                   addr == conv_pkg::ADDR_CHAN     ? chan_q :
                   addr == conv_pkg::ADDR_REF_GAIN ? refg_q :
                   addr == conv_pkg::ADDR_RES_LOW  ? res_low_q :
                   addr == conv_pkg::ADDR_RES_HIGH ? res_high_q :
                   addr == conv_pkg::ADDR_POWER    ? {7'h00, power_off_q} : 8'h00;

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_b_q    <= conv_pkg::RESET_BYTE;
         chan_q      <= conv_pkg::RESET_BYTE;
         refg_q      <= conv_pkg::RESET_BYTE;
         power_off_q <= 1'b0;
         rdata       <= 8'h00;
      end else begin
         rdata <= rd ? rd_mux : 8'h00;
         if (wr && addr == conv_pkg::ADDR_CTRL_B) ctrl_b_q <= wdata;
         if (wr && addr == conv_pkg::ADDR_CHAN) chan_q <= wdata;
         if (wr && addr == conv_pkg::ADDR_REF_GAIN) refg_q <= wdata;
         if (wr && addr == conv_pkg::ADDR_POWER) power_off_q <= wdata[conv_pkg::BIT_POWER_OFF];
      end
   end

   // Control A: flag set wins over the write-one clear.
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_a_q <= conv_pkg::RESET_BYTE;
      end else begin
         if (wr_a) begin
            ctrl_a_q[7]   <= wdata[7];
            ctrl_a_q[5]   <= wdata[5];
            ctrl_a_q[3:0] <= wdata[3:0];
         end
         ctrl_a_q[6] <= 1'b0;
         if (finish) begin
            ctrl_a_q[conv_pkg::BIT_FLAG] <= 1'b1;
         end else if (wr_a && wdata[conv_pkg::BIT_FLAG]) begin
            ctrl_a_q[conv_pkg::BIT_FLAG] <= 1'b0;
         end
      end
   end

   // Prescaler is cleared while disabled and at a triggered start, two cycles after the accepted edge.
   always_ff @(posedge clock) begin
      if (rst || !conv_enable || sync_q == 2'h1) begin
         presc_q <= 8'h00;
         cclk_q  <= 1'b0;
      end else begin
         presc_q <= presc_q + 8'h01;
         if (half_tick) cclk_q <= ~cclk_q;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         trig_q  <= 1'b0;
         sync_q  <= 2'h0;
         sleep_q <= 1'b0;
         pend_q  <= 1'b0;
      end else begin
         trig_q  <= trig_now;
         sleep_q <= cpu_sleep_quiet;
         // Two CPU cycles pass between the edge and the conversion start.
         if (trig_edge && conv_enable) sync_q <= conv_pkg::SYNC_CPU_CYCLES;
         else if (sync_q != 2'h0) sync_q <= sync_q - 2'h1;
         if (!conv_enable || sw_go) pend_q <= 1'b0;
         else if ((wr_a && wdata[conv_pkg::BIT_START])
                  || (cpu_sleep_quiet && !sleep_q && !busy_q
                      && !ctrl_a_q[conv_pkg::BIT_AUTO])) pend_q <= 1'b1;
      end
   end

   // Conversion timing in half conversion-clock periods.
   always_ff @(posedge clock) begin
      if (rst || !conv_enable) begin
         busy_q     <= 1'b0;
         first_q    <= 1'b1;
         half_q     <= 6'h00;
         len_q      <= conv_pkg::HALF_NORMAL;
         sh_q       <= conv_pkg::HALF_SH_NORM;
         sel_last_q <= 9'h000;
      end else if (sw_go || sync_q == 2'h1 || restart) begin
         busy_q     <= 1'b1;
         half_q     <= 6'h00;
         first_q    <= 1'b0;
         sel_last_q <= {chan_q[5:0], refg_q[2:0]};
         if (first_q || sel_change) begin
            len_q <= conv_pkg::HALF_FIRST;
            sh_q  <= conv_pkg::HALF_SH_FIRST;
         end else if (sync_q == 2'h1) begin
            len_q <= conv_pkg::HALF_AUTO;
            sh_q  <= conv_pkg::HALF_SH_AUTO;
         end else begin
            len_q <= conv_pkg::HALF_NORMAL;
            sh_q  <= conv_pkg::HALF_SH_NORM;
         end
      end else if (finish) begin
         busy_q <= 1'b0;
      end else if (busy_q && half_tick) begin
         half_q <= half_q + 6'h01;
      end
   end

   // Result bytes and the read lock between low and high byte reads.
   always_ff @(posedge clock) begin
      if (rst) begin
         res_low_q  <= 8'h00;
         res_high_q <= 8'h00;
         lock_q     <= 1'b0;
      end else begin
         if (rd_high) lock_q <= 1'b0;
         else if (rd_low) lock_q <= 1'b1;
         if (finish && !lock_q) begin
            res_low_q  <= res_word[7:0];
            res_high_q <= res_word[15:8];
         end
      end
   end

   // Selections are frozen during a conversion and only driven while enabled.
   always_ff @(posedge clock) begin
      if (rst) begin
         analog_enable    <= 1'b0;
         analog_channel   <= 6'h00;
         analog_reference <= 3'h0;
         analog_sample    <= 1'b0;
         analog_busy      <= 1'b0;
      end else begin
         analog_enable <= conv_enable;
         analog_busy   <= busy_q;
         analog_sample <= busy_q && half_tick && half_q == sh_q - 6'h01;
         if (conv_enable && !busy_q && !sw_go && sync_q == 2'h0) begin
            analog_channel   <= chan_q[5:0];
            analog_reference <= refg_q[2:0];
         end
      end
   end

   AST_FLAG_ON_FINISH: assert property (@(posedge clock) disable iff (rst)
      finish |=> ctrl_a_q[conv_pkg::BIT_FLAG]) else $error("flag not set");
   AST_LOCK_HOLDS: assert property (@(posedge clock) disable iff (rst)
      (finish && lock_q) |=> $stable(res_low_q) && $stable(res_high_q))
      else $error("result updated under lock");
   AST_START_READS: assert property (@(posedge clock) disable iff (rst)
      busy_q |-> rd_mux[6] || addr != conv_pkg::ADDR_CTRL_A)
      else $error("start bit low during conversion");
   AST_PRESC_HELD: assert property (@(posedge clock) disable iff (rst)
      !conv_enable |=> presc_q == 8'h00) else $error("prescaler ran");
   AST_CHAN_FROZEN: assert property (@(posedge clock) disable iff (rst)
      (busy_q && $past(busy_q)) |-> $stable(analog_channel))
      else $error("channel changed mid conversion");
   AST_FREE_RUN: assert property (@(posedge clock) disable iff (rst)
      restart |=> busy_q) else $error("no restart");
   AST_NO_TRIG_BUSY: assert property (@(posedge clock) disable iff (rst)
      busy_q |-> !trig_edge) else $error("edge accepted while busy");
   AST_SYNC_START: assert property (@(posedge clock) disable iff (rst)
      (trig_edge && conv_enable) |-> ##3 busy_q) else $error("trigger start late");
   AST_SW_DONE: assert property (@(posedge clock) disable iff (rst)
      (finish && !restart) |=> !busy_q) else $error("busy after end");
   COV_SINGLE: cover property (@(posedge clock) sw_go ##[1:1000] finish);
   COV_TRIGGER: cover property (@(posedge clock) trig_edge);
   COV_LOCK_LOSS: cover property (@(posedge clock) finish && lock_q);
endmodule : sar_adc_sequencer

/* File: tb/analog_core_model.sv */
`timescale 1ns/100ps
module analog_core_model (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst,
   // Converter side.
   input  wire logic       busy,
   input  wire logic [9:0] next_value,
   output      logic [9:0] sar_result
);
   logic busy_q;
   // A code is taken at each rise of busy and held until the next, so a late sample still sees it.
   always_ff @(posedge clock) begin
      busy_q <= busy;
      if (rst) begin
         sar_result <= 10'h000;
      end else if (busy && !busy_q) begin
         sar_result <= next_value;
      end
   end
endmodule : analog_core_model

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
   logic        clock, rst, wr, rd, cpu_sleep_quiet, gain_active;
   logic        analog_enable, analog_sample, analog_busy;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, trig_sources, d;
   logic [9:0]  sar_result, next_value;
   logic [5:0]  analog_channel;
   logic [2:0]  analog_reference;
   logic [31:0] rng;
   logic [15:0] w;
   int          err_count, checks_done, run, last_len, n_done, n_sample, n0, res_model;
   bit          lock_model, left_model;
   sar_adc_sequencer dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .trig_sources(trig_sources), .cpu_sleep_quiet(cpu_sleep_quiet),
      .gain_active(gain_active), .sar_result(sar_result), .analog_enable(analog_enable),
      .analog_channel(analog_channel), .analog_reference(analog_reference),
      .analog_sample(analog_sample), .analog_busy(analog_busy));
   analog_core_model core (.clock(clock), .rst(rst), .busy(analog_busy),
      .next_value(next_value), .sar_result(sar_result));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      rng <= xorshift(rng);
      next_value <= rng[9:0];
      if (analog_sample) n_sample++;
      if (analog_busy) run++;
      else if (run != 0) begin
         last_len = run;
         n_done++;
         run = 0;
         if (!lock_model) res_model = sar_result;
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic wait_conv();
      int k;
      k = n_done;
      for (int i = 0; i < 3000 && n_done == k; i++) @(posedge clock);
   endtask : wait_conv
   // The start alignment to the divided clock is left open, hence the tolerance.
   task automatic chk_len(input int exp);
      check(16'(last_len >= exp - exp / 5 && last_len <= exp + exp / 5), 16'h1);
   endtask : chk_len
   task automatic chk_result();
      w = left_model ? {res_model[9:0], 6'h00} : {6'h00, res_model[9:0]};
      rd_reg(conv_pkg::ADDR_RES_LOW);
      lock_model = 1'b1;
      check({8'h00, d}, {8'h00, w[7:0]});
      rd_reg(conv_pkg::ADDR_RES_HIGH);
      lock_model = 1'b0;
      check({8'h00, d}, {8'h00, w[15:8]});
   endtask : chk_result
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (40000) @(posedge clock);
      err_count++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      {wr, rd, addr, wdata, trig_sources, cpu_sleep_quiet, gain_active} = 24'h000000;
      rng = 32'hd5b2632d;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      rd_reg(conv_pkg::ADDR_CTRL_A);
      check({8'h00, d}, 16'h0000);
      rd_reg(4'hf);
      check({8'h00, d}, 16'h0000);
      wr_reg(conv_pkg::ADDR_POWER, 8'h00);
      wr_reg(conv_pkg::ADDR_CHAN, 8'h15);
      repeat (4) @(posedge clock);
      check({10'h0, analog_channel}, 16'h0000);
      wr_reg(conv_pkg::ADDR_CTRL_A, 8'h80);
      repeat (4) @(posedge clock);
      check({10'h0, analog_channel}, 16'h0015);
      wr_reg(conv_pkg::ADDR_CTRL_A, 8'hc0);
      rd_reg(conv_pkg::ADDR_CTRL_A);
      check({15'h0, d[6]}, 16'h1);
      wr_reg(conv_pkg::ADDR_CHAN, 8'h2a);
      check({10'h0, analog_channel}, 16'h0015);
      wait_conv();
      chk_len(52);
      repeat (4) @(posedge clock);
      check({10'h0, analog_channel}, 16'h002a);
      rd_reg(conv_pkg::ADDR_CTRL_A);
      check({13'h0, d[6:4]}, 16'h1);
      chk_result();
      for (int ps = 0; ps < 3; ps++) begin
         wr_reg(conv_pkg::ADDR_CTRL_A, 8'hd0 | 8'(ps));
         wait_conv();
         chk_len(30 << ps);
         chk_result();
      end
      wr_reg(conv_pkg::ADDR_CTRL_B, 8'h08);
      left_model = 1'b1;
      wr_reg(conv_pkg::ADDR_CTRL_A, 8'hd0);
      wait_conv();
      chk_result();
      rd_reg(conv_pkg::ADDR_RES_LOW);
      lock_model = 1'b1;
      wr_reg(conv_pkg::ADDR_CTRL_A, 8'hd0);
      wait_conv();
      rd_reg(conv_pkg::ADDR_CTRL_A);
      check({15'h0, d[4]}, 16'h1);
      chk_result();
      wr_reg(conv_pkg::ADDR_CTRL_B, 8'h01);
      left_model = 1'b0;
      wr_reg(conv_pkg::ADDR_CTRL_A, 8'hb0);
      n0 = n_done;
      trig_sources <= 8'h02;
      repeat (12) @(posedge clock);
      trig_sources <= 8'h00;
      repeat (12) @(posedge clock);
      trig_sources <= 8'h02;
      repeat (200) @(posedge clock);
      check(16'(n_done - n0), 16'h1);
      chk_len(31);
      chk_result();
      trig_sources <= 8'h00;
      wr_reg(conv_pkg::ADDR_CTRL_A, 8'h90);
      n0 = n_done;
      cpu_sleep_quiet <= 1'b1;
      repeat (100) @(posedge clock);
      cpu_sleep_quiet <= 1'b0;
      check(16'(n_done - n0), 16'h1);
      gain_active <= 1'b1;
      wr_reg(conv_pkg::ADDR_CHAN, 8'h07);
      wr_reg(conv_pkg::ADDR_CTRL_A, 8'hd0);
      wait_conv();
      chk_len(52);
      check({10'h0, analog_channel}, 16'h0007);
      chk_result();
      gain_active <= 1'b0;
      wr_reg(conv_pkg::ADDR_CTRL_B, 8'h00);
      wr_reg(conv_pkg::ADDR_CTRL_A, 8'hf0);
      n0 = n_sample;
      repeat (300) @(posedge clock);
      check(16'(n_sample - n0 >= 8 && n_sample - n0 <= 11), 16'h1);
      rd_reg(conv_pkg::ADDR_CTRL_A);
      check({15'h0, d[6]}, 16'h1);
      wr_reg(conv_pkg::ADDR_CTRL_A, 8'h00);
      repeat (4) @(posedge clock);
      check({15'h0, analog_enable}, 16'h0);
      end_of_test();
   end
endmodule : tb
